// [rtl/prescaler_pkg.sv]
// Shared constants for the timer prescaler block.
package prescaler_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SEL_W = 3;
    localparam int PRESCALE_WIDTH = 10;

    // Register byte offsets.
    localparam logic [7:0] OFS_SYNC_CONTROL = 8'h00;
    localparam logic [7:0] OFS_SELECT_A = 8'h04;
    localparam logic [7:0] OFS_SELECT_B = 8'h08;
    localparam logic [7:0] OFS_PRESCALE_COUNT = 8'h0c;

    // Field positions in general_timer_sync_control.
    localparam int SYNC_CLEAR_BIT = 0;
    localparam int ASYNC_CLEAR_BIT = 1;
    localparam int HOLD_MODE_BIT = 7;

    // Reset values.
    localparam logic [7:0] SYNC_CONTROL_RESET = 8'h00;
    localparam logic [2:0] SELECT_RESET = 3'h0;

    // Counter bits that must all be one for each divider tap.
    localparam int TAP_DIV8_BITS = 3;
    localparam int TAP_DIV64_BITS = 6;
    localparam int TAP_DIV256_BITS = 8;
    localparam int TAP_DIV1024_BITS = 10;

    typedef enum logic [2:0] {
        SRC_STOPPED = 3'h0,
        SRC_DIRECT = 3'h1,
        SRC_DIV8 = 3'h2,
        SRC_DIV64 = 3'h3,
        SRC_DIV256 = 3'h4,
        SRC_DIV1024 = 3'h5,
        SRC_PIN_FALL = 3'h6,
        SRC_PIN_RISE = 3'h7
    } tick_source_e;

endpackage

// [rtl/pin_edge_sync.sv]
// Count pin synchronizer with rising and falling edge detector.
`timescale 1ns/1ns
module pin_edge_sync
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic rise,
    output logic fall
);
    logic pin_latch;
    logic sync_q;
    logic prev_q;

    // The latch is open in the high phase, so a pin edge is seen half a cycle sooner
    // than with a second flip-flop; this gives the 2.5 to 3.5 cycle pin latency.
    always_latch
    begin
        if (pclk)
        begin
            pin_latch <= pin;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            sync_q <= pin_latch;
            prev_q <= sync_q;
        end
    end

    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;

endmodule

// [rtl/shared_timer_prescaler.sv]
// Shared prescaler, clock source selection and pin edge ticks for two timers.
`timescale 1ns/1ns
// Summary of operation
// - One prescaler serves both timers; each timer has its own source select.
// - Select value one gives a tick on every clock cycle.
// - Taps at clock divided by 8, 64, 256 and 1024 are selectable.
// - The prescaler runs freely; first tap tick comes 1 to N cycles later.
// - Clearing the prescaler restarts the tap periods for both timers.
// - Each count pin is sampled every cycle and fed to an edge detector.
// - Sampling uses a rising edge register and a high-transparent latch.
// - Select seven ticks on rising pin edges, six on falling pin edges.
// - Pin edge to counter update takes 2.5 to 3.5 clock cycles.
// - Pin ticks bypass the divider taps entirely.
// - While hold mode is one, both clear bits keep their written values.
// - Writing hold mode to zero clears both clear bits together.
// - The synchronous clear bit resets the prescaler and self-clears unless held.
// - Select value zero gives no ticks, stopping the timer.
// - Pin edges count even when the pin is driven as an output.
module shared_timer_prescaler
#(
    parameter int PRESCALE_W = prescaler_pkg::PRESCALE_WIDTH
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [prescaler_pkg::ADDR_W-1:0] paddr,
    input wire logic [prescaler_pkg::DATA_W-1:0] pwdata,
    output logic [prescaler_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_count_pin_a,
    input wire logic ext_count_pin_b,
    output logic timer_a_tick,
    output logic timer_b_tick,
    output logic sync_prescaler_reset,
    output logic async_prescaler_reset
);
    import prescaler_pkg::*;

    if (PRESCALE_W < TAP_DIV1024_BITS || PRESCALE_W > DATA_W)
    begin : g_width_check
        $error("PRESCALE_W cannot hold the largest divider tap");
    end

    logic bus_write;
    logic bus_setup;
    logic ctrl_write;
    logic sync_hold_mode_q;
    logic sync_prescaler_clear_q;
    logic async_prescaler_clear_q;
    logic [SEL_W-1:0] tick_source_select_a_q;
    logic [SEL_W-1:0] tick_source_select_b_q;
    logic [PRESCALE_W-1:0] count_q;
    logic tap8;
    logic tap64;
    logic tap256;
    logic tap1024;
    logic rise_a;
    logic fall_a;
    logic rise_b;
    logic fall_b;
    logic tick_a_q;
    logic tick_b_q;
    logic tick_a_d;
    logic tick_b_d;
    logic [DATA_W-1:0] prdata_q;
    logic [DATA_W-1:0] prdata_d;
    logic slverr_q;
    logic slverr_d;

    // APB decode; every access completes without wait states.
    assign bus_write = psel & penable & pwrite;
    assign bus_setup = psel & ~penable;
    assign ctrl_write = bus_write && (paddr == OFS_SYNC_CONTROL);
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = slverr_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_hold_mode_q <= SYNC_CONTROL_RESET[HOLD_MODE_BIT];
        end
        else if (ctrl_write)
        begin
            sync_hold_mode_q <= pwdata[HOLD_MODE_BIT];
        end
    end

    // A written one always lasts at least one cycle, so the reset is never lost.
    // After that the bit stays only while hold mode is set.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_prescaler_clear_q <= SYNC_CONTROL_RESET[SYNC_CLEAR_BIT];
        end
        else if (ctrl_write)
        begin
            sync_prescaler_clear_q <= pwdata[SYNC_CLEAR_BIT];
        end
        else if (!sync_hold_mode_q)
        begin
            sync_prescaler_clear_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            async_prescaler_clear_q <= SYNC_CONTROL_RESET[ASYNC_CLEAR_BIT];
        end
        else if (ctrl_write)
        begin
            async_prescaler_clear_q <= pwdata[ASYNC_CLEAR_BIT];
        end
        else if (!sync_hold_mode_q)
        begin
            async_prescaler_clear_q <= 1'b0;
        end
    end

    assign sync_prescaler_reset = sync_prescaler_clear_q;
    assign async_prescaler_reset = async_prescaler_clear_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_source_select_a_q <= SELECT_RESET;
            tick_source_select_b_q <= SELECT_RESET;
        end
        else if (bus_write)
        begin
            if (paddr == OFS_SELECT_A)
            begin
                tick_source_select_a_q <= pwdata[SEL_W-1:0];
            end
            else if (paddr == OFS_SELECT_B)
            begin
                tick_source_select_b_q <= pwdata[SEL_W-1:0];
            end
        end
    end

    // The counter ignores both selects, so a timer that starts on a tap sees a
    // first tick anywhere within one tap period.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_q <= '0;
        end
        else if (sync_prescaler_clear_q)
        begin
            count_q <= '0;
        end
        else
        begin
            count_q <= count_q + 1'b1;
        end
    end

    assign tap8 = &count_q[TAP_DIV8_BITS-1:0];
    assign tap64 = &count_q[TAP_DIV64_BITS-1:0];
    assign tap256 = &count_q[TAP_DIV256_BITS-1:0];
    assign tap1024 = &count_q[TAP_DIV1024_BITS-1:0];

    // The pin is read as an input regardless of its port direction.
    pin_edge_sync u_sync_a
    (
        .pclk(pclk),
        .presetn(presetn),
        .pin(ext_count_pin_a),
        .rise(rise_a),
        .fall(fall_a)
    );

    pin_edge_sync u_sync_b
    (
        .pclk(pclk),
        .presetn(presetn),
        .pin(ext_count_pin_b),
        .rise(rise_b),
        .fall(fall_b)
    );

    function automatic logic pick_tick(
        input logic [SEL_W-1:0] sel,
        input logic t8,
        input logic t64,
        input logic t256,
        input logic t1024,
        input logic rise,
        input logic fall
    );
        logic hit;
        hit = 1'b0;
        case (tick_source_e'(sel))
            SRC_STOPPED: hit = 1'b0;
            SRC_DIRECT: hit = 1'b1;
            SRC_DIV8: hit = t8;
            SRC_DIV64: hit = t64;
            SRC_DIV256: hit = t256;
            SRC_DIV1024: hit = t1024;
            SRC_PIN_FALL: hit = fall;
            SRC_PIN_RISE: hit = rise;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    always_comb
    begin
        tick_a_d = pick_tick(tick_source_select_a_q, tap8, tap64, tap256, tap1024,
            rise_a, fall_a);
        tick_b_d = pick_tick(tick_source_select_b_q, tap8, tap64, tap256, tap1024,
            rise_b, fall_b);
    end

    // Registering the tick keeps glitches off the timer enables; the timer
    // updates one edge later, which lands the pin latency at 2.5 to 3.5 cycles.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_a_q <= 1'b0;
            tick_b_q <= 1'b0;
        end
        else
        begin
            tick_a_q <= tick_a_d;
            tick_b_q <= tick_b_d;
        end
    end

    assign timer_a_tick = tick_a_q;
    assign timer_b_tick = tick_b_q;

    // Read data is captured in the setup cycle and presented in the access cycle.
    always_comb
    begin
        prdata_d = '0;
        slverr_d = 1'b0;
        if (paddr == OFS_SYNC_CONTROL)
        begin
            prdata_d[HOLD_MODE_BIT] = sync_hold_mode_q;
            prdata_d[ASYNC_CLEAR_BIT] = async_prescaler_clear_q;
            prdata_d[SYNC_CLEAR_BIT] = sync_prescaler_clear_q;
        end
        else if (paddr == OFS_SELECT_A)
        begin
            prdata_d[SEL_W-1:0] = tick_source_select_a_q;
        end
        else if (paddr == OFS_SELECT_B)
        begin
            prdata_d[SEL_W-1:0] = tick_source_select_b_q;
        end
        else if (paddr == OFS_PRESCALE_COUNT)
        begin
            prdata_d[PRESCALE_W-1:0] = count_q;
        end
        else
        begin
            slverr_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= '0;
            slverr_q <= 1'b0;
        end
        else if (bus_setup)
        begin
            prdata_q <= pwrite ? '0 : prdata_d;
            slverr_q <= slverr_d;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_release_write;
        ctrl_write && !pwdata[HOLD_MODE_BIT];
    endsequence

    // A write in the same cycle wins over the self-clear, so it is left out here.
    sequence s_quiet_then_clear;
        !sync_hold_mode_q ##0 !ctrl_write;
    endsequence

    a_direct_every_cycle: assert property (
        tick_source_select_a_q == SRC_DIRECT |=> timer_a_tick)
        else $error("direct source missed a tick");

    a_stopped_no_tick: assert property (
        tick_source_select_b_q == SRC_STOPPED |=> !timer_b_tick)
        else $error("stopped source produced a tick");

    a_div8_tap_tick: assert property (
        tick_source_select_a_q == SRC_DIV8 |=>
        timer_a_tick == ($past(count_q[2:0]) == 3'h7))
        else $error("divide by 8 tick misplaced");

    a_counter_free_run: assert property (
        !sync_prescaler_clear_q |=> count_q == $past(count_q) + 1'b1)
        else $error("prescaler did not advance");

    a_clear_restarts: assert property (
        sync_prescaler_clear_q |=> count_q == '0 ##1
        count_q == {{(PRESCALE_W-1){1'b0}}, !$past(sync_prescaler_clear_q)})
        else $error("prescaler clear did not restart count");

    a_hold_keeps_clear: assert property (
        sync_hold_mode_q && !ctrl_write |=> $stable(sync_prescaler_clear_q)
        && $stable(async_prescaler_clear_q))
        else $error("held clear bits changed");

    a_release_clears: assert property (
        s_release_write ##1 !ctrl_write |=> !sync_prescaler_clear_q && !async_prescaler_clear_q)
        else $error("hold release left clear bits set");

    a_self_clear: assert property (
        s_quiet_then_clear |=> !sync_prescaler_clear_q)
        else $error("sync clear bit did not self-clear");

    a_pin_rise_direct: assert property (
        tick_source_select_a_q == SRC_PIN_RISE |=> timer_a_tick == $past(rise_a))
        else $error("rising pin tick mismatch");

    a_pin_fall_direct: assert property (
        tick_source_select_b_q == SRC_PIN_FALL |=> timer_b_tick == $past(fall_b))
        else $error("falling pin tick mismatch");

endmodule

// [test/timer_core_model.sv]
// Behavioural model of the two timer cores that consume the count ticks.
`timescale 1ns/1ns
module timer_core_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic timer_a_tick,
    input wire logic timer_b_tick,
    output logic [31:0] count_a,
    output logic [31:0] count_b
);
    // Each core advances only on its own enable, never on the other one.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_a <= 32'h0;
        end
        else if (timer_a_tick)
        begin
            count_a <= count_a + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_b <= 32'h0;
        end
        else if (timer_b_tick)
        begin
            count_b <= count_b + 32'h1;
        end
    end
endmodule

// [test/tb_top.sv]
// Self-checking bench for the shared timer prescaler.
`timescale 1ns/1ns
module tb_top;
    import prescaler_pkg::*;
    typedef struct {tick_source_e sa; tick_source_e sb; int ea; int eb;} row_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pin_lvl = 1'b0;
    logic [31:0] prdata, count_a, count_b, rd, a0, b0;
    logic pready, pslverr, er, timer_a_tick, timer_b_tick;
    logic sync_prescaler_reset, async_prescaler_reset;
    int err_total = 0;
    int compares = 0;
    int k;
    // A window of 2048 cycles holds a whole number of every tap period.
    row_s rows[6] = '{'{SRC_STOPPED, SRC_DIV1024, 0, 2}, '{SRC_DIRECT, SRC_DIV256, 2048, 8},
        '{SRC_DIV8, SRC_DIV64, 256, 32}, '{SRC_DIV64, SRC_DIV8, 32, 256},
        '{SRC_DIV256, SRC_DIRECT, 8, 2048}, '{SRC_DIV1024, SRC_STOPPED, 2, 0}};

    shared_timer_prescaler i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_count_pin_a(pin_lvl),
        .ext_count_pin_b(pin_lvl), .timer_a_tick(timer_a_tick), .timer_b_tick(timer_b_tick),
        .sync_prescaler_reset(sync_prescaler_reset),
        .async_prescaler_reset(async_prescaler_reset));
    timer_core_model i_model (.pclk(pclk), .presetn(presetn), .timer_a_tick(timer_a_tick),
        .timer_b_tick(timer_b_tick), .count_a(count_a), .count_b(count_b));

    always #25 pclk = ~pclk;

    task automatic tally_and_finish();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Settle after the edge so registered outputs and model counts have landed.
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            err_total++;
            tally_and_finish();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, experr});
    endtask

    task automatic pins(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            pin_lvl <= 1'b1;
            repeat (3) @(posedge pclk);
            pin_lvl <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask

    task automatic poll_a(input int lim);
        k = 0;
        do
        begin
            cyc(1);
            k++;
        end
        while (timer_a_tick !== 1'b1 && k < lim);
        if (k >= lim)
        begin
            err_total++;
            tally_and_finish();
        end
    endtask

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(OFS_SYNC_CONTROL, 32'h0, 1'b0);
        rdchk(OFS_SELECT_A, 32'h0, 1'b0);
        rdchk(OFS_SELECT_B, 32'h0, 1'b0);
        apb(1'b1, 8'h10, 32'h83);
        rdchk(8'h10, 32'h0, 1'b1);
        foreach (rows[i])
        begin
            apb(1'b1, OFS_SELECT_A, {29'h0, rows[i].sa});
            apb(1'b1, OFS_SELECT_B, {29'h0, rows[i].sb});
            cyc(4);
            a0 = count_a;
            b0 = count_b;
            cyc(2048);
            chk(count_a - a0, 32'(rows[i].ea));
            chk(count_b - b0, 32'(rows[i].eb));
        end
        apb(1'b1, OFS_SYNC_CONTROL, 32'h1);
        apb(1'b0, OFS_PRESCALE_COUNT, 32'h0);
        chk({31'h0, rd < 32'h4}, 32'h1);
        rdchk(OFS_SYNC_CONTROL, 32'h0, 1'b0);
        apb(1'b1, OFS_SELECT_A, {29'h0, SRC_DIV8});
        apb(1'b1, OFS_SYNC_CONTROL, 32'h83);
        cyc(2);
        chk({31'h0, sync_prescaler_reset}, 32'h1);
        chk({31'h0, async_prescaler_reset}, 32'h1);
        a0 = count_a;
        cyc(40);
        chk(count_a - a0, 32'h0);
        rdchk(OFS_SYNC_CONTROL, 32'h83, 1'b0);
        // Pin edges must still count while the divider is held.
        apb(1'b1, OFS_SELECT_A, {29'h0, SRC_PIN_RISE});
        apb(1'b1, OFS_SELECT_B, {29'h0, SRC_PIN_FALL});
        cyc(4);
        a0 = count_a;
        b0 = count_b;
        pins(5);
        cyc(6);
        chk(count_a - a0, 32'h5);
        chk(count_b - b0, 32'h5);
        @(posedge pclk);
        pin_lvl <= 1'b1;
        poll_a(10);
        chk({31'h0, k >= 2 && k <= 3}, 32'h1);
        @(posedge pclk);
        pin_lvl <= 1'b0;
        cyc(4);
        apb(1'b1, OFS_SELECT_A, {29'h0, SRC_DIV8});
        apb(1'b1, OFS_SYNC_CONTROL, 32'h0);
        poll_a(20);
        chk({31'h0, k >= 1 && k <= 11}, 32'h1);
        chk({30'h0, sync_prescaler_reset, async_prescaler_reset}, 32'h0);
        rdchk(OFS_SYNC_CONTROL, 32'h0, 1'b0);
        presetn <= 1'b0;
        cyc(3);
        chk({29'h0, pready, timer_a_tick, timer_b_tick}, 32'h4);
        @(posedge pclk);
        presetn <= 1'b1;
        rdchk(OFS_SELECT_A, 32'h0, 1'b0);
        tally_and_finish();
    end
endmodule
